// ==== eirq_defines.svh ====
`ifndef EIRQ_DEFINES_SVH
`define EIRQ_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define EIRQ_OFS_EXT_CTRL 8'h00
`define EIRQ_OFS_INT_STATUS 8'h04
`define EIRQ_OFS_INT_MASK 8'h08
`define EIRQ_OFS_VEC_STATUS 8'h0c

// ****************************************
// Field positions of the external request control register
// ****************************************
`define EIRQ_BIT_PULL_DISABLE 0
`define EIRQ_BIT_EDGE_SELECT 1
`define EIRQ_BIT_PIN_ENABLE 2
`define EIRQ_BIT_FLAG 3
`define EIRQ_BIT_ACK 4
`define EIRQ_BIT_INT_ENABLE 5
`define EIRQ_BIT_DETECT_MODE 6
`define EIRQ_BIT_PIN_LEVEL 7

// ****************************************
// Reset values, vector layout and bus answers
// ****************************************
`define EIRQ_CTRL_RESET 5'h00
`define EIRQ_MASK_RESET 3'h0
`define EIRQ_VEC_TOP 16'hfffe
`define EIRQ_VEC_EXT 5'd3
`define EIRQ_RESP_OKAY 2'h0
`define EIRQ_RESP_SLVERR 2'h2

`endif

// ==== eirq_pkg.sv ====
`default_nettype none

package eirq_pkg;

    typedef enum logic [3:0] {
        EIRQ_IDLE = 4'h0,
        EIRQ_PUSH_PCL = 4'h1,
        EIRQ_PUSH_PCH = 4'h3,
        EIRQ_PUSH_X = 4'h2,
        EIRQ_PUSH_A = 4'h6,
        EIRQ_PUSH_CCR = 4'h7,
        EIRQ_SET_MASK = 4'h5,
        EIRQ_FETCH_HI = 4'h4,
        EIRQ_FETCH_LO = 4'hc
    } eirq_seq_t;

    typedef enum logic [2:0] {
        EIRQ_REG_CTRL = 3'h0,
        EIRQ_REG_STATUS = 3'h1,
        EIRQ_REG_MASK = 3'h2,
        EIRQ_REG_VEC = 3'h3,
        EIRQ_REG_NONE = 3'h7
    } eirq_reg_t;

    typedef struct packed {
        logic software_interrupt;
        logic low_supply_flag;
        logic low_supply_int_enable;
        logic t1_channel_zero_flag;
        logic t1_channel_zero_enable;
        logic t1_channel_one_flag;
        logic t1_channel_one_enable;
        logic t1_timer_overflow_flag;
        logic t1_timer_overflow_enable;
        logic t2_channel_zero_flag;
        logic t2_channel_zero_enable;
        logic t2_timer_overflow_flag;
        logic t2_timer_overflow_enable;
        logic keypad_flag;
        logic keypad_int_enable;
        logic conversion_complete_flag;
        logic conversion_int_enable;
        logic periodic_wake_flag;
        logic periodic_wake_enable;
    } eirq_src_t;

    typedef struct packed {
        logic watchdog_timeout;
        logic watchdog_enable;
        logic low_supply_reset;
        logic low_supply_reset_enable;
        logic reset_pin;
        logic reset_pin_enable;
        logic illegal_opcode;
        logic illegal_address;
        logic power_on;
    } eirq_rst_src_t;

    typedef struct packed {
        logic detect_mode;
        logic int_enable;
        logic pin_enable;
        logic edge_select;
        logic pull_disable;
    } eirq_ctrl_t;

    typedef struct packed {
        eirq_ctrl_t ctrl;
        logic flag;
        logic prev_asserted;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        eirq_seq_t seq;
        logic [4:0] vec_num;
        logic [15:0] fetch_addr;
        logic reset_req;
    } eirq_state_t;

endpackage : eirq_pkg

`default_nettype wire

// ==== eirq_prio.sv ====
`include "eirq_defines.svh"
`default_nettype none

// ****************************************
// Fixed-priority pick: the lowest vector number wins
// ****************************************
module eirq_prio (
    input wire logic [31:0] req,
    output logic pending,
    output logic [4:0] vec_num,
    output logic [15:0] vec_addr
);

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] n;
        n = 5'h1f;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                n = 5'(i);
            end
        end
        return n;
    endfunction : lowest_set

    always_comb begin
        pending = |req;
        vec_num = lowest_set(req);
        // Each vector is a byte pair, so the pair moves down by two.
        vec_addr = `EIRQ_VEC_TOP - {10'h000, vec_num, 1'b0};
    end

endmodule : eirq_prio

`default_nettype wire

// ==== eirq_top.sv ====
// Summary of operation
// - The pin acts as request input only while the pin enable bit is set.
// - Software picks the active polarity through the edge select bit.
// - Edge select 0 means falling or low; 1 means rising or high.
// - Detect mode chooses edges only or edges plus levels.
// - An event either raises an interrupt or only sets the polled flag.
// - Enabled pin with pull disable clear gets a pull matching polarity.
// - Pull disable set turns the internal pull device off.
// - While enabled, the pin level feeds the branch-on-level instructions.
// - The flag sets on a move from deasserted to asserted level.
// - In level mode the flag stays set while the pin stays asserted.
// - Every source sets its flag; requests pass only with local enable, except the software interrupt, which has none.
// - Unmasked, the core stacks five registers, sets mask, fetches vector.
// - Vector high byte sits at the lower address, low byte next.
// - Vectors 0 to 31 descend from top to FFC0; lower number wins.
// - Fixed source to vector numbers for pin, supply, timers and others.
// - Gated reset sources and unconditional ones all go to vector 0.
// - Enabled pin is sampled synchronously; a direct path wakes stop mode.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`include "eirq_defines.svh"
`default_nettype none

module eirq_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_req_pin,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic branch_if_pin_high,
    output logic branch_if_pin_low,
    output logic ext_req_wake,
    input wire eirq_pkg::eirq_src_t src,
    input wire eirq_pkg::eirq_rst_src_t rst_src,
    input wire logic cpu_insn_done,
    input wire logic global_mask,
    output logic int_pending,
    output logic stack_push,
    output eirq_pkg::eirq_seq_t stack_sel,
    output logic set_global_mask,
    output logic vec_fetch,
    output logic [15:0] vec_fetch_addr,
    output logic reset_req,
    output logic irq
);

    // ****************************************
    // Address decode shared by reads and writes
    // ****************************************
    function automatic eirq_pkg::eirq_reg_t decode(input logic [7:0] a);
        eirq_pkg::eirq_reg_t r;
        if (a == `EIRQ_OFS_EXT_CTRL) begin
            r = eirq_pkg::EIRQ_REG_CTRL;
        end else if (a == `EIRQ_OFS_INT_STATUS) begin
            r = eirq_pkg::EIRQ_REG_STATUS;
        end else if (a == `EIRQ_OFS_INT_MASK) begin
            r = eirq_pkg::EIRQ_REG_MASK;
        end else if (a == `EIRQ_OFS_VEC_STATUS) begin
            r = eirq_pkg::EIRQ_REG_VEC;
        end else begin
            r = eirq_pkg::EIRQ_REG_NONE;
        end
        return r;
    endfunction : decode

    eirq_pkg::eirq_state_t st_reg;
    eirq_pkg::eirq_state_t st_next;
    logic asserted;
    logic set_flag;
    logic ack;
    logic wr_go;
    logic rd_go;
    logic [31:0] req;
    logic prio_pending;
    logic [4:0] prio_num;
    logic [15:0] prio_addr;
    logic start;
    logic [2:0] events;
    logic [31:0] rd_val;
    eirq_pkg::eirq_reg_t wsel;
    eirq_pkg::eirq_reg_t rsel;

    // ****************************************
    // Request collection
    // ****************************************
    always_comb begin
        req = 32'h0000_0000;
        req[1] = src.software_interrupt;
        req[2] = src.low_supply_flag & src.low_supply_int_enable;
        // Flag-only operation is simply the local enable left clear.
        req[3] = st_reg.flag & st_reg.ctrl.int_enable;
        req[5] = src.t1_channel_zero_flag & src.t1_channel_zero_enable;
        req[6] = src.t1_channel_one_flag & src.t1_channel_one_enable;
        req[7] = src.t1_timer_overflow_flag & src.t1_timer_overflow_enable;
        req[8] = src.t2_channel_zero_flag & src.t2_channel_zero_enable;
        req[10] = src.t2_timer_overflow_flag & src.t2_timer_overflow_enable;
        req[18] = src.keypad_flag & src.keypad_int_enable;
        req[19] = src.conversion_complete_flag & src.conversion_int_enable;
        req[23] = src.periodic_wake_flag & src.periodic_wake_enable;
    end

    eirq_prio u_prio (
        .req(req),
        .pending(prio_pending),
        .vec_num(prio_num),
        .vec_addr(prio_addr)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Pin is taken as synchronous to clk, so it is used directly.
        asserted = (ext_req_pin == st_reg.ctrl.edge_select);
        set_flag = st_reg.ctrl.pin_enable & asserted
                   & (~st_reg.prev_asserted | st_reg.ctrl.detect_mode);
        wr_go = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
        wsel = decode(st_reg.awaddr);
        rd_go = s_axi_arvalid & ~st_reg.rvalid;
        rsel = decode(s_axi_araddr);
        ack = wr_go & (wsel == eirq_pkg::EIRQ_REG_CTRL) & st_reg.wstrb0
              & st_reg.wdata[`EIRQ_BIT_ACK];
        start = (st_reg.seq == eirq_pkg::EIRQ_IDLE) & cpu_insn_done
                & ~global_mask & prio_pending;
        events = {set_flag & ~st_reg.flag, start,
                  st_next.reset_req & ~st_reg.reset_req};

        // A disabled pin parks the history as asserted, so enabling the
        // pin while it already sits at the active level is not an edge.
        st_next.prev_asserted = st_reg.ctrl.pin_enable ? asserted : 1'b1;
        // Set wins over the acknowledge, which also keeps level mode held.
        st_next.flag = set_flag | (st_reg.flag & ~ack);

        st_next.reset_req = (rst_src.watchdog_timeout
            & rst_src.watchdog_enable)
            | (rst_src.low_supply_reset & rst_src.low_supply_reset_enable)
            | (rst_src.reset_pin & rst_src.reset_pin_enable)
            | rst_src.illegal_opcode | rst_src.illegal_address
            | rst_src.power_on;
        events[0] = st_next.reset_req & ~st_reg.reset_req;

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid & ~st_reg.aw_have & ~st_reg.bvalid) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~st_reg.w_have & ~st_reg.bvalid) begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.bvalid & s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = (wsel == eirq_pkg::EIRQ_REG_NONE)
                            ? `EIRQ_RESP_SLVERR : `EIRQ_RESP_OKAY;
            if (st_reg.wstrb0 & (wsel == eirq_pkg::EIRQ_REG_CTRL)) begin
                st_next.ctrl.pull_disable =
                    st_reg.wdata[`EIRQ_BIT_PULL_DISABLE];
                st_next.ctrl.edge_select =
                    st_reg.wdata[`EIRQ_BIT_EDGE_SELECT];
                st_next.ctrl.pin_enable =
                    st_reg.wdata[`EIRQ_BIT_PIN_ENABLE];
                st_next.ctrl.int_enable =
                    st_reg.wdata[`EIRQ_BIT_INT_ENABLE];
                st_next.ctrl.detect_mode =
                    st_reg.wdata[`EIRQ_BIT_DETECT_MODE];
            end
            if (st_reg.wstrb0 & (wsel == eirq_pkg::EIRQ_REG_MASK)) begin
                st_next.int_mask = st_reg.wdata[2:0];
            end
        end

        // Read channel: status clears on the read, new events survive it.
        rd_val = 32'h0000_0000;
        if (rsel == eirq_pkg::EIRQ_REG_CTRL) begin
            rd_val[`EIRQ_BIT_PULL_DISABLE] = st_reg.ctrl.pull_disable;
            rd_val[`EIRQ_BIT_EDGE_SELECT] = st_reg.ctrl.edge_select;
            rd_val[`EIRQ_BIT_PIN_ENABLE] = st_reg.ctrl.pin_enable;
            rd_val[`EIRQ_BIT_FLAG] = st_reg.flag;
            rd_val[`EIRQ_BIT_INT_ENABLE] = st_reg.ctrl.int_enable;
            rd_val[`EIRQ_BIT_DETECT_MODE] = st_reg.ctrl.detect_mode;
            rd_val[`EIRQ_BIT_PIN_LEVEL] = ext_req_pin;
        end else if (rsel == eirq_pkg::EIRQ_REG_STATUS) begin
            rd_val[2:0] = st_reg.int_status;
        end else if (rsel == eirq_pkg::EIRQ_REG_MASK) begin
            rd_val[2:0] = st_reg.int_mask;
        end else if (rsel == eirq_pkg::EIRQ_REG_VEC) begin
            rd_val = {10'h000, prio_pending, st_reg.fetch_addr,
                      st_reg.vec_num};
        end
        if (st_reg.rvalid & s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        st_next.int_status = st_reg.int_status | events;
        if (rd_go) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_val;
            st_next.rresp = (rsel == eirq_pkg::EIRQ_REG_NONE)
                            ? `EIRQ_RESP_SLVERR : `EIRQ_RESP_OKAY;
            if (rsel == eirq_pkg::EIRQ_REG_STATUS) begin
                st_next.int_status = events;
            end
        end

        // Interrupt entry sequence seen from the core's side.
        case (st_reg.seq)
            eirq_pkg::EIRQ_IDLE: begin
                if (start) begin
                    st_next.seq = eirq_pkg::EIRQ_PUSH_PCL;
                end
            end
            eirq_pkg::EIRQ_PUSH_PCL: begin
                st_next.seq = eirq_pkg::EIRQ_PUSH_PCH;
            end
            eirq_pkg::EIRQ_PUSH_PCH: begin
                st_next.seq = eirq_pkg::EIRQ_PUSH_X;
            end
            eirq_pkg::EIRQ_PUSH_X: begin
                st_next.seq = eirq_pkg::EIRQ_PUSH_A;
            end
            eirq_pkg::EIRQ_PUSH_A: begin
                st_next.seq = eirq_pkg::EIRQ_PUSH_CCR;
            end
            eirq_pkg::EIRQ_PUSH_CCR: begin
                st_next.seq = eirq_pkg::EIRQ_SET_MASK;
            end
            eirq_pkg::EIRQ_SET_MASK: begin
                // The winner is chosen late so a newer, higher request
                // that arrived during stacking is the one served.
                st_next.seq = eirq_pkg::EIRQ_FETCH_HI;
                st_next.vec_num = prio_num;
                st_next.fetch_addr = prio_addr;
            end
            eirq_pkg::EIRQ_FETCH_HI: begin
                st_next.seq = eirq_pkg::EIRQ_FETCH_LO;
                st_next.fetch_addr = st_reg.fetch_addr + 16'h0001;
            end
            default: begin
                st_next.seq = eirq_pkg::EIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.ctrl <= `EIRQ_CTRL_RESET;
            st_reg.int_mask <= `EIRQ_MASK_RESET;
            st_reg.seq <= eirq_pkg::EIRQ_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = ~st_reg.aw_have & ~st_reg.bvalid;
    assign s_axi_wready = ~st_reg.w_have & ~st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign pull_up_en = st_reg.ctrl.pin_enable & ~st_reg.ctrl.pull_disable
                        & ~st_reg.ctrl.edge_select;
    assign pull_down_en = st_reg.ctrl.pin_enable & ~st_reg.ctrl.pull_disable
                          & st_reg.ctrl.edge_select;
    assign branch_if_pin_high = st_reg.ctrl.pin_enable & ext_req_pin;
    assign branch_if_pin_low = st_reg.ctrl.pin_enable & ~ext_req_pin;
    // Unclocked on purpose: it must work while the bus clock is stopped.
    assign ext_req_wake = st_reg.ctrl.pin_enable & asserted;
    assign int_pending = prio_pending;
    assign stack_sel = st_reg.seq;
    assign stack_push = (st_reg.seq != eirq_pkg::EIRQ_IDLE)
                        & (st_reg.seq != eirq_pkg::EIRQ_SET_MASK)
                        & (st_reg.seq != eirq_pkg::EIRQ_FETCH_HI)
                        & (st_reg.seq != eirq_pkg::EIRQ_FETCH_LO);
    assign set_global_mask = (st_reg.seq == eirq_pkg::EIRQ_SET_MASK);
    assign vec_fetch = (st_reg.seq == eirq_pkg::EIRQ_FETCH_HI)
                       | (st_reg.seq == eirq_pkg::EIRQ_FETCH_LO);
    assign vec_fetch_addr = st_reg.fetch_addr;
    assign reset_req = st_reg.reset_req;
    assign irq = |(st_reg.int_status & st_reg.int_mask);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_stacking;
        stack_sel == eirq_pkg::EIRQ_PUSH_PCL ##1
        stack_sel == eirq_pkg::EIRQ_PUSH_PCH ##1
        stack_sel == eirq_pkg::EIRQ_PUSH_X ##1
        stack_sel == eirq_pkg::EIRQ_PUSH_A ##1
        stack_sel == eirq_pkg::EIRQ_PUSH_CCR;
    endsequence
    sequence s_mask_fetch;
        set_global_mask ##1 vec_fetch[*2];
    endsequence

    a_pin_disabled: assert property (!st_reg.ctrl.pin_enable && !st_reg.flag
        |-> !ext_req_wake ##1 !st_reg.flag)
        else $error("flag set while pin disabled");
    a_edge_sets: assert property (st_reg.ctrl.pin_enable && asserted
        && !st_reg.prev_asserted |=> st_reg.flag)
        else $error("edge did not set flag");
    a_level_holds: assert property (st_reg.ctrl.pin_enable
        && st_reg.ctrl.detect_mode && asserted |=> st_reg.flag)
        else $error("level mode flag cleared");
    a_pull_polarity: assert property (st_reg.ctrl.pin_enable
        && !st_reg.ctrl.pull_disable |-> (pull_up_en != pull_down_en)
        && (pull_down_en == st_reg.ctrl.edge_select))
        else $error("wrong pull direction");
    a_pull_off: assert property (st_reg.ctrl.pull_disable
        |-> !pull_up_en && !pull_down_en)
        else $error("pull on while disabled");
    a_pin_view: assert property (st_reg.ctrl.pin_enable
        |-> branch_if_pin_high == ext_req_pin
        && branch_if_pin_low == !ext_req_pin)
        else $error("pin level not presented");
    a_no_request: assert property (st_reg.seq == eirq_pkg::EIRQ_IDLE
        && req == 32'h0000_0000 |=> st_reg.seq == eirq_pkg::EIRQ_IDLE)
        else $error("entry without enabled request");
    a_entry_order: assert property (start
        |=> s_stacking ##1 s_mask_fetch)
        else $error("entry sequence out of order");
    a_vec_pair: assert property (stack_sel == eirq_pkg::EIRQ_FETCH_HI
        |=> vec_fetch_addr == $past(vec_fetch_addr) + 16'h0001)
        else $error("vector low byte not next");
    a_vec_map: assert property (stack_sel == eirq_pkg::EIRQ_FETCH_HI
        |-> vec_fetch_addr
        == `EIRQ_VEC_TOP - {10'h000, st_reg.vec_num, 1'b0})
        else $error("vector address mismatch");

endmodule : eirq_top

`default_nettype wire

// ==== eirq_core_model.sv ====
`default_nettype none

// ****************************************
// Core model: slow instruction ends, mask, stack and fetch log
// ****************************************
module eirq_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic allow,
    input wire logic stack_push,
    input wire eirq_pkg::eirq_seq_t stack_sel,
    input wire logic set_global_mask,
    input wire logic vec_fetch,
    input wire logic [15:0] vec_fetch_addr,
    output logic cpu_insn_done,
    output logic global_mask,
    output logic done,
    output logic [19:0] pushed,
    output logic [31:0] fetched
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge clk) begin
        if (!rst_b || !allow) begin
            cpu_insn_done <= 1'b0;
            global_mask <= 1'b1;
            done <= 1'b0;
            pushed <= 20'h00000;
            fetched <= 32'h00000000;
        end else begin
            // An instruction ends only every other cycle, so entry waits.
            cpu_insn_done <= ~cpu_insn_done;
            if (stack_push) pushed <= {pushed[15:0], stack_sel};
            if (vec_fetch) fetched <= {fetched[15:0], vec_fetch_addr};
            if (set_global_mask) begin
                global_mask <= 1'b1;
                done <= 1'b1;
            end else if (!done) begin
                global_mask <= 1'b0;
            end
        end
    end
endmodule : eirq_core_model

`default_nettype wire

// ==== test_external_irq_and_vector_priority.sv ====
`default_nettype none

module test_external_irq_and_vector_priority;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, fetched, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_req_pin = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, pull_up_en, pull_down_en, branch_if_pin_high;
    logic branch_if_pin_low, ext_req_wake, int_pending, stack_push;
    logic set_global_mask, vec_fetch, reset_req, irq, cpu_insn_done;
    logic global_mask, done, allow = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] vec_fetch_addr;
    logic [19:0] pushed;
    eirq_pkg::eirq_seq_t stack_sel;
    eirq_pkg::eirq_src_t src = 19'h00000;
    eirq_pkg::eirq_rst_src_t rst_src = 9'h000;
    int bad_count = 0, checks_done = 0, cyc = 0;

    eirq_top dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_req_pin, .pull_up_en, .pull_down_en,
        .branch_if_pin_high, .branch_if_pin_low, .ext_req_wake, .src, .rst_src,
        .cpu_insn_done, .global_mask, .int_pending, .stack_push, .stack_sel,
        .set_global_mask, .vec_fetch, .vec_fetch_addr, .reset_req, .irq);
    eirq_core_model core (.clk, .rst_b, .allow, .stack_push, .stack_sel,
        .set_global_mask, .vec_fetch, .vec_fetch_addr, .cpu_insn_done,
        .global_mask, .done, .pushed, .fetched);

    always #12.5 clk = ~clk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // The ceiling is far above the fewer than two hundred cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), e, rd);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rs});
    endtask : rc

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rc(8'h00, 32'h0, 2'h0);
        rc(8'h08, 32'h0, 2'h0);
        rc(8'h04, 32'h0, 2'h0);
        rc(8'h10, 32'h0, 2'h2);
        chk("branch low", 32'h0, {31'h0, branch_if_pin_low});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 8'h04 | 8'(i));
            chk("pull up", 32'(i == 0), {31'h0, pull_up_en});
            chk("pull dn", 32'(i == 2), {31'h0, pull_down_en});
        end
        $display("test pull done");
        ext_req_pin <= 1'b1;
        wr(8'h00, 8'h14);
        rc(8'h00, 32'h84, 2'h0);
        ext_req_pin <= 1'b0;
        repeat (3) @(posedge clk);
        rc(8'h00, 32'h0c, 2'h0);
        chk("branch low", 32'h1, {31'h0, branch_if_pin_low});
        chk("wake", 32'h1, {31'h0, ext_req_wake});
        chk("pending", 32'h0, {31'h0, int_pending});
        wr(8'h00, 8'h14);
        rc(8'h00, 32'h04, 2'h0);
        wr(8'h00, 8'h54);
        rc(8'h00, 32'h4c, 2'h0);
        wr(8'h00, 8'h54);
        rc(8'h00, 32'h4c, 2'h0);
        ext_req_pin <= 1'b1;
        wr(8'h00, 8'h54);
        rc(8'h00, 32'hc4, 2'h0);
        chk("branch high", 32'h1, {31'h0, branch_if_pin_high});
        $display("test flag done");
        wr(8'h00, 8'h24);
        ext_req_pin <= 1'b0;
        src.low_supply_flag <= 1'b1;
        src.low_supply_int_enable <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pending", 32'h1, {31'h0, int_pending});
        for (int n = 2; n < 4; n++) begin
            allow <= 1'b1;
            do @(posedge clk); while (!done);
            repeat (3) @(posedge clk);
            chk("fetch", {16'hfffe - 16'(2 * n), 16'hffff - 16'(2 * n)},
                fetched);
            chk("stack", 32'h13267, {12'h0, pushed});
            allow <= 1'b0;
            src <= 19'h00000;
            @(posedge clk);
        end
        rc(8'h0c, 32'h003fff23, 2'h0);
        $display("test vector done");
        wr(8'h08, 8'h04);
        chk("irq", 32'h1, {31'h0, irq});
        rc(8'h04, 32'h06, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        rst_src.power_on <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset req", 32'h1, {31'h0, reset_req});
        chk("irq", 32'h0, {31'h0, irq});
        rc(8'h04, 32'h01, 2'h0);
        rc(8'h08, 32'h04, 2'h0);
        $display("test status done");
        stop_test();
    end
endmodule : test_external_irq_and_vector_priority

`default_nettype wire
